// ==== dv/ccs_channel_config_select_test.sv ====
// Self-checking bench of the lane configuration selector.
// Assumes ccs_host drives the bus; straps are driven here.
module ccs_channel_config_select_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_in, rst_in, ca, cfg, scl, pull, sda_o, sda_oe, lp;
    logic        chk, ack;
    logic [3:0]  bsel, en, ad;
    logic [1:0]  sw, fg;
    logic [15:0] boost;
    logic [7:0]  swing, gain, pd, rb;
    logic [31:0] rnd, lanes;
    logic [36:0] notes[$];
    int          errors, tests_run;
    wire         sda = !(pull | sda_oe);
    ccs_channel_config_select ccs_channel_config_select_i (.clk_in(clk_in),
        .rst_in(rst_in), .cable_absent_in(ca),
        .config_source_select_in(cfg), .boost_select_in(bsel),
        .output_level_select_in(sw), .dc_gain_select_in(fg), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_o), .sda_oe_out(sda_oe),
        .lane_boost_out(boost), .lane_swing_out(swing),
        .lane_gain_out(gain), .lane_enable_out(en), .low_power_out(lp));
    ccs_host ccs_host_i (.clk_in(clk_in), .sda_in(sda), .scl_out(scl),
        .sda_pull_out(pull));
    function automatic logic [31:0] xs(logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    function automatic logic [36:0] bus_exp(logic [31:0] l, logic [7:0] p,
                                            logic a);
        logic [36:0] e;
        e = {33'h0, a};
        for (int i = 0; i < 4; i++) begin
            e[21+4*i +: 4] = l[8*i+4 +: 4];
            e[13+2*i +: 2] = l[8*i +: 2];
            e[5+2*i +: 2] = l[8*i+2 +: 2];
            e[1+i] = !a && !p[4+i];
        end
        return e;
    endfunction
    task automatic check(string what, logic [36:0] seen, logic [36:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic expect_out(logic [36:0] v);
        notes.push_back(v);
        repeat (2) @(posedge clk_in);
        chk <= 1'b1;
        @(posedge clk_in);
        chk <= 1'b0;
    endtask
    task automatic test_done();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(negedge clk_in) begin
        if (chk === 1'b1)
            check("lanes", {boost, swing, gain, en, lp}, notes.pop_front());
    end
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    initial begin
        repeat (20000) @(posedge clk_in);
        errors++;
        test_done();
    end
    initial begin
        {rst_in, ca, cfg, bsel, sw, fg, chk, errors, tests_run} = '0;
        rst_in = 1'b1;
        rnd = 32'h0000_0058;
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        for (int i = 0; i < 10; i++) begin
            rnd = xs(rnd);
            if (i == 0)
                rnd[7:4] = 4'h0;
            {ca, bsel, sw, fg} <= rnd[8:0];
            expect_out({{4{rnd[7:4]}}, {4{rnd[3:2]}}, {4{rnd[1:0]}},
                        {4{!rnd[8]}}, rnd[8]});
        end
        rnd = xs(rnd);
        {ad, pd, lanes} = {rnd[3:0], rnd[15:12], 4'h0, xs(rnd)};
        {cfg, ca, bsel, fg} <= {2'b10, ad, 2'b10};
        @(posedge clk_in);
        ccs_host_i.start_cond();
        ccs_host_i.send_byte({3'h7, ad, 1'b0}, ack);
        check("ack", 37'(ack), 37'(1));
        ccs_host_i.send_byte(8'h02, ack);
        ccs_host_i.send_byte(pd, ack);
        for (int k = 0; k < 4; k++)
            ccs_host_i.send_byte(lanes[8*k +: 8], ack);
        ccs_host_i.stop_cond();
        expect_out(bus_exp(lanes, pd, 1'b0));
        ca <= 1'b1;
        expect_out(bus_exp(lanes, pd, 1'b1));
        ccs_host_i.start_cond();
        ccs_host_i.send_byte({3'h7, ad, 1'b0}, ack);
        ccs_host_i.send_byte(8'h03, ack);
        ccs_host_i.stop_cond();
        ccs_host_i.start_cond();
        ccs_host_i.send_byte({3'h7, ad, 1'b1}, ack);
        check("read ack", 37'(ack), 37'(1));
        ccs_host_i.recv_byte(1'b1, rb);
        ccs_host_i.stop_cond();
        check("read", 37'(rb), 37'(lanes[7:0]));
        check("sda_out", 37'(sda_o), 37'(0));
        ccs_host_i.start_cond();
        ccs_host_i.send_byte({3'h7, ~ad, 1'b0}, ack);
        check("nack", 37'(ack), 37'(0));
        ccs_host_i.stop_cond();
        fg <= 2'b00;
        expect_out(bus_exp(32'h0000_0000, 8'h00, 1'b1));
        {cfg, ca, fg, bsel, sw} <= 10'h000;
        expect_out({32'h0000_0000, 5'h1e});
        test_done();
    end
endmodule

// ==== dv/ccs_chk.sv ====
// Assertions on the lane configuration selector outputs.
// Assumes it is bound to ccs_channel_config_select, one clock domain.
module ccs_chk (
    input wire logic        clk_in,
    input wire logic        rst_in,
    input wire logic        cable_absent_in,
    input wire logic        config_source_select_in,
    input wire logic [3:0]  boost_select_in,
    input wire logic [1:0]  output_level_select_in,
    input wire logic [1:0]  dc_gain_select_in,
    input wire logic        sda_oe_out,
    input wire logic [15:0] lane_boost_out,
    input wire logic [7:0]  lane_swing_out,
    input wire logic [7:0]  lane_gain_out,
    input wire logic [3:0]  lane_enable_out,
    input wire logic        low_power_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    sequence strap_s;
        !$past(rst_in) && !$past(config_source_select_in);
    endsequence
    low_power_a: assert property (!$past(rst_in) |->
        low_power_out == $past(cable_absent_in)) else $error("low power");
    strap_enable_a: assert property (strap_s |->
        lane_enable_out == {4{!$past(cable_absent_in)}}) else $error("enable");
    absent_off_a: assert property (!$past(rst_in) &&
        $past(cable_absent_in) |-> lane_enable_out == 4'h0) else $error("off");
    strap_boost_a: assert property (strap_s |->
        lane_boost_out == {4{$past(boost_select_in)}}) else $error("boost");
    strap_swing_a: assert property (strap_s |->
        lane_swing_out == {4{$past(output_level_select_in)}})
        else $error("swing");
    strap_gain_a: assert property (strap_s |->
        lane_gain_out == {4{$past(dc_gain_select_in)}}) else $error("gain");
    reg_clear_a: assert property (config_source_select_in &&
        !dc_gain_select_in[1] ##1 config_source_select_in |=>
        lane_boost_out == 16'h0000 && lane_gain_out == 8'h00)
        else $error("clear");
    bus_quiet_a: assert property (!config_source_select_in [*3] |->
        !sda_oe_out) else $error("bus quiet");
    cover property ($rose(sda_oe_out));
    cover property (config_source_select_in && cable_absent_in);
    cover property (config_source_select_in && !dc_gain_select_in[1]);
endmodule

bind ccs_channel_config_select ccs_chk ccs_chk_i (.clk_in, .rst_in,
    .cable_absent_in, .config_source_select_in, .boost_select_in,
    .output_level_select_in, .dc_gain_select_in, .sda_oe_out,
    .lane_boost_out, .lane_swing_out, .lane_gain_out, .lane_enable_out,
    .low_power_out);

// ==== dv/ccs_host.sv ====
// Two-wire bus host model with open-drain data pull.
// Assumes the bench resolves the data wire with a pull-up.
module ccs_host (
    input  wire logic clk_in,
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_pull_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        scl_out = 1'b1;
        sda_pull_out = 1'b0;
    end
    // Three cycles a phase, above the two the target needs
    task automatic half();
        repeat (3) @(posedge clk_in);
    endtask
    task automatic start_cond();
        sda_pull_out <= 1'b1;
        half();
        scl_out <= 1'b0;
        half();
    endtask
    task automatic stop_cond();
        sda_pull_out <= 1'b1;
        half();
        scl_out <= 1'b1;
        half();
        sda_pull_out <= 1'b0;
        half();
    endtask
    // Reads one byte MSB first, then acknowledges unless it is the last
    task automatic recv_byte(input logic last, output logic [7:0] b);
        for (int i = 7; i >= -1; i--) begin
            sda_pull_out <= (i >= 0) ? 1'b0 : !last;
            half();
            scl_out <= 1'b1;
            half();
            if (i >= 0)
                b[i] = sda_in;
            scl_out <= 1'b0;
            half();
        end
    endtask
    // Data moves only while scl is low, so no false start or stop
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= -1; i--) begin
            sda_pull_out <= (i >= 0) ? !b[i] : 1'b0;
            half();
            scl_out <= 1'b1;
            half();
            ack = !sda_in;
            scl_out <= 1'b0;
            half();
        end
    endtask
endmodule

// ==== logic/ccs_channel_config_select.sv ====
// Lane configuration selector: strap pins or two-wire bus registers
// drive the per-lane boost, swing, flat gain and enable settings.
// Assumes scl and sda already synchronous to clk_in and far slower.
//
// What this block does
// RULE_01 - Cable absent input high forces low power
// RULE_02 - Cable absent low enables normal lane operation
// RULE_03 - Cable absent acts in both configuration sources
// RULE_04 - Source select low takes settings from straps
// RULE_05 - Source select high takes settings from registers
// RULE_06 - Strap boost code drives all four lanes
// RULE_07 - Strap output level code drives all lanes
// RULE_08 - Strap flat gain code drives all lanes
// RULE_09 - Register clear low restores register defaults
// RULE_10 - Four strap inputs form bus target address
// RULE_11 - Bus mode holds separate settings per lane
// RULE_12 - Per-lane power down only through registers
// RULE_13 - Boost code zero is the weakest level
// RULE_14 - Shared pins interpreted by source select level
module ccs_channel_config_select (
    input  wire logic                                    clk_in,
    input  wire logic                                    rst_in,
    input  wire logic                                    cable_absent_in,
    input  wire logic                                    config_source_select_in,
    input  wire logic [ccs_pkg::BOOST_W-1:0]             boost_select_in,
    input  wire logic [ccs_pkg::SWING_W-1:0]             output_level_select_in,
    input  wire logic [ccs_pkg::GAIN_W-1:0]              dc_gain_select_in,
    input  wire logic                                    scl_in,
    input  wire logic                                    sda_in,
    output logic                                         sda_out,
    output logic                                         sda_oe_out,
    output logic [ccs_pkg::LANES*ccs_pkg::BOOST_W-1:0]   lane_boost_out,
    output logic [ccs_pkg::LANES*ccs_pkg::SWING_W-1:0]   lane_swing_out,
    output logic [ccs_pkg::LANES*ccs_pkg::GAIN_W-1:0]    lane_gain_out,
    output logic [ccs_pkg::LANES-1:0]                    lane_enable_out,
    output logic                                         low_power_out
);

    ccs_pkg::ccs_regs_type s_q;
    ccs_pkg::ccs_regs_type s_d;

    function automatic logic in_map(input logic [7:0] p);
        in_map = (p >= ccs_pkg::REG_POWER_DOWN) && (p <= ccs_pkg::REG_LAST);
    endfunction

    function automatic logic [2:0] reg_idx(input logic [7:0] p);
        logic [7:0] d;
        d = p - ccs_pkg::REG_POWER_DOWN;
        reg_idx = d[2:0];
    endfunction

    function automatic logic [7:0] read_byte(
        input logic [ccs_pkg::NUM_REGS-1:0][7:0] r,
        input logic [7:0]                        p
    );
        read_byte = 8'h00;
        if (in_map(p)) begin
            read_byte = r[reg_idx(p)];
        end
    endfunction

    logic       i2c_mode;
    logic       rise;
    logic       fall;
    logic       start;
    logic       stop;
    logic [6:0] my_addr;
    logic [7:0] rbyte;
    logic [7:0] cfg;

    always_comb begin
        s_d      = s_q;
        rbyte    = 8'h00;
        cfg      = 8'h00;
        i2c_mode = config_source_select_in; // RULE_04 RULE_05
        // Address straps reuse the boost pins; only valid in bus mode
        my_addr  = {ccs_pkg::ADDR_PREFIX, boost_select_in}; // RULE_10 RULE_14
        s_d.scl  = scl_in;
        s_d.sda  = sda_in;
        rise     = !s_q.scl && scl_in;
        fall     = s_q.scl && !scl_in;
        start    = s_q.scl && scl_in && s_q.sda && !sda_in;
        stop     = s_q.scl && scl_in && !s_q.sda && sda_in;

        case (s_q.st)
            ccs_pkg::ST_ADDR: begin
                if (rise) begin
                    s_d.shreg = {s_q.shreg[6:0], sda_in};
                    s_d.bits  = s_q.bits + 4'h1;
                end
                if (fall && s_q.bits == ccs_pkg::BITS_BYTE) begin
                    if (s_q.shreg[7:1] == my_addr) begin
                        s_d.st      = ccs_pkg::ST_ACK;
                        s_d.sda_drv = 1'b1;
                        s_d.rw      = s_q.shreg[0];
                        s_d.got_ptr = 1'b0;
                    end else begin
                        s_d.st = ccs_pkg::ST_IDLE;
                    end
                end
            end
            ccs_pkg::ST_ACK: begin
                if (fall) begin
                    s_d.bits = 4'h0;
                    if (s_q.rw) begin
                        rbyte       = read_byte(s_q.regs, s_q.ptr);
                        s_d.shreg   = rbyte;
                        s_d.ptr     = s_q.ptr + 8'h01;
                        s_d.sda_drv = !rbyte[7];
                        s_d.st      = ccs_pkg::ST_TX;
                    end else begin
                        s_d.sda_drv = 1'b0;
                        s_d.st      = ccs_pkg::ST_RX;
                    end
                end
            end
            ccs_pkg::ST_RX: begin
                if (rise) begin
                    s_d.shreg = {s_q.shreg[6:0], sda_in};
                    s_d.bits  = s_q.bits + 4'h1;
                end
                if (fall && s_q.bits == ccs_pkg::BITS_BYTE) begin
                    if (!s_q.got_ptr) begin
                        s_d.ptr     = s_q.shreg;
                        s_d.got_ptr = 1'b1;
                    end else begin
                        // Reserved bytes swallow writes
                        if (in_map(s_q.ptr)) begin
                            s_d.regs[reg_idx(s_q.ptr)] = s_q.shreg; // RULE_11 RULE_12
                        end
                        s_d.ptr = s_q.ptr + 8'h01;
                    end
                    s_d.st      = ccs_pkg::ST_ACK;
                    s_d.sda_drv = 1'b1;
                end
            end
            ccs_pkg::ST_TX: begin
                if (rise) begin
                    s_d.bits = s_q.bits + 4'h1;
                end
                if (fall) begin
                    if (s_q.bits == ccs_pkg::BITS_BYTE) begin
                        s_d.sda_drv = 1'b0;
                        s_d.st      = ccs_pkg::ST_MACK;
                    end else begin
                        s_d.shreg   = {s_q.shreg[6:0], 1'b0};
                        s_d.sda_drv = !s_q.shreg[6];
                    end
                end
            end
            ccs_pkg::ST_MACK: begin
                // A not-acknowledge ends the read; wait for stop or start
                if (rise && sda_in) begin
                    s_d.st = ccs_pkg::ST_IDLE;
                end else if (fall) begin
                    rbyte       = read_byte(s_q.regs, s_q.ptr);
                    s_d.shreg   = rbyte;
                    s_d.ptr     = s_q.ptr + 8'h01;
                    s_d.sda_drv = !rbyte[7];
                    s_d.bits    = 4'h0;
                    s_d.st      = ccs_pkg::ST_TX;
                end
            end
            default: begin
                s_d.st = ccs_pkg::ST_IDLE;
            end
        endcase

        if (start) begin
            s_d.st      = ccs_pkg::ST_ADDR;
            s_d.bits    = 4'h0;
            s_d.sda_drv = 1'b0;
        end else if (stop) begin
            s_d.st      = ccs_pkg::ST_IDLE;
            s_d.sda_drv = 1'b0;
        end

        // In strap mode the address pins are boost straps, so stay deaf
        if (!i2c_mode) begin
            s_d.st      = ccs_pkg::ST_IDLE; // RULE_14
            s_d.sda_drv = 1'b0;
        end

        // Clear shares a pin with a gain strap; it counts only in bus mode
        if (i2c_mode && !dc_gain_select_in[1]) begin
            s_d.regs = {ccs_pkg::NUM_REGS{ccs_pkg::REG_RESET_VAL}}; // RULE_09 RULE_14
        end

        s_d.low_power = cable_absent_in; // RULE_01 RULE_02 RULE_03
        for (int i = 0; i < ccs_pkg::LANES; i++) begin
            if (i2c_mode) begin
                cfg = s_q.regs[i + 1];
                // Boost code passes straight through, zero weakest
                s_d.boost[i*ccs_pkg::BOOST_W +: ccs_pkg::BOOST_W] =
                    cfg[ccs_pkg::BOOST_LSB +: ccs_pkg::BOOST_W]; // RULE_11 RULE_13
                s_d.swing[i*ccs_pkg::SWING_W +: ccs_pkg::SWING_W] =
                    cfg[ccs_pkg::SWING_LSB +: ccs_pkg::SWING_W]; // RULE_11
                s_d.gain[i*ccs_pkg::GAIN_W +: ccs_pkg::GAIN_W] =
                    cfg[ccs_pkg::GAIN_LSB +: ccs_pkg::GAIN_W]; // RULE_11
                s_d.lane_en[i] = !cable_absent_in
                    && !s_q.regs[0][ccs_pkg::PD_LSB + i]; // RULE_03 RULE_12
            end else begin
                s_d.boost[i*ccs_pkg::BOOST_W +: ccs_pkg::BOOST_W] =
                    boost_select_in; // RULE_06 RULE_13
                s_d.swing[i*ccs_pkg::SWING_W +: ccs_pkg::SWING_W] =
                    output_level_select_in; // RULE_07
                s_d.gain[i*ccs_pkg::GAIN_W +: ccs_pkg::GAIN_W] =
                    dc_gain_select_in; // RULE_08
                s_d.lane_en[i] = !cable_absent_in; // RULE_01 RULE_02
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s_q      <= '0;
            s_q.st   <= ccs_pkg::ST_IDLE;
            s_q.scl  <= 1'b1;
            s_q.sda  <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Open drain: only ever pulls low
    assign sda_out         = 1'b0;
    assign sda_oe_out      = s_q.sda_drv;
    assign lane_boost_out  = s_q.boost;
    assign lane_swing_out  = s_q.swing;
    assign lane_gain_out   = s_q.gain;
    assign lane_enable_out = s_q.lane_en;
    assign low_power_out   = s_q.low_power;

endmodule

// ==== logic/ccs_pkg.sv ====
// Constants, state encoding and state record of the lane configuration
// selector. Assumes one 50 MHz clock and synchronous inputs.
package ccs_pkg;

    localparam int unsigned LANES      = 4;
    localparam int unsigned BOOST_W    = 4;
    localparam int unsigned SWING_W    = 2;
    localparam int unsigned GAIN_W     = 2;
    localparam int unsigned ADDR_W     = 4;

    // Register byte pointers seen from the two-wire bus
    localparam logic [7:0]  REG_POWER_DOWN = 8'h02;
    localparam logic [7:0]  REG_LANE_FIRST = 8'h03;
    localparam logic [7:0]  REG_LAST       = 8'h06;
    localparam int unsigned NUM_REGS       = 5;
    localparam logic [7:0]  REG_RESET_VAL  = 8'h00;

    // Field positions inside a lane byte and the power-down byte
    localparam int unsigned BOOST_LSB  = 4;
    localparam int unsigned GAIN_LSB   = 2;
    localparam int unsigned SWING_LSB  = 0;
    localparam int unsigned PD_LSB     = 4;

    // Fixed upper part of the 7-bit target address
    localparam logic [2:0]  ADDR_PREFIX = 3'h7;
    localparam logic [3:0]  BITS_BYTE   = 4'h8;

    typedef enum logic [5:0] {
        ST_IDLE = 6'b00_0001,
        ST_ADDR = 6'b00_0010,
        ST_ACK  = 6'b00_0100,
        ST_RX   = 6'b00_1000,
        ST_TX   = 6'b01_0000,
        ST_MACK = 6'b10_0000
    } ccs_state_type;

    typedef struct packed {
        ccs_state_type                     st;
        logic                              scl;
        logic                              sda;
        logic [3:0]                        bits;
        logic [7:0]                        shreg;
        logic                              rw;
        logic                              got_ptr;
        logic [7:0]                        ptr;
        logic [NUM_REGS-1:0][7:0]          regs;
        logic                              sda_drv;
        logic [LANES*BOOST_W-1:0]          boost;
        logic [LANES*SWING_W-1:0]          swing;
        logic [LANES*GAIN_W-1:0]           gain;
        logic [LANES-1:0]                  lane_en;
        logic                              low_power;
    } ccs_regs_type;

endpackage
